// ==== verilog/fcdma_pkg.sv ====
// Shared constants and types of the four-channel DMA pin-level controller
package fcdma_pkg;

    localparam int NCH = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Register selects on the low address lines while programming
    localparam logic [3:0] RS_CMD_STAT = 4'h8;
    localparam logic [3:0] RS_REQUEST = 4'h9;
    localparam logic [3:0] RS_MASK_ONE = 4'hA;
    localparam logic [3:0] RS_MODE = 4'hB;
    localparam logic [3:0] RS_CLR_PTR = 4'hC;
    localparam logic [3:0] RS_MCLR_TEMP = 4'hD;
    localparam logic [3:0] RS_CLR_MASK = 4'hE;
    localparam logic [3:0] RS_ALL_MASK = 4'hF;

    ////////////////////////////////////////////////////////////////////////////
    // Command register bit positions
    localparam int CMD_MEM2MEM = 0;
    localparam int CMD_DISABLE = 2;
    localparam int CMD_REQ_LOW = 6;
    localparam int CMD_ACK_HIGH = 7;

    // Mode word (stored from data bits 7:2): [1:0] type, [2] auto, [3] down, [5:4] service
    localparam int MODE_AUTO = 2;
    localparam int MODE_DEC = 3;
    localparam int MODE_SVC = 4;
    localparam logic [1:0] XFER_VERIFY = 2'h0;
    localparam logic [1:0] XFER_WRITE = 2'h1;
    localparam logic [1:0] XFER_READ = 2'h2;
    localparam logic [1:0] SVC_DEMAND = 2'h0;
    localparam logic [1:0] SVC_SINGLE = 2'h1;
    localparam logic [1:0] SVC_BLOCK = 2'h2;
    localparam logic [1:0] SVC_CASCADE = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Synchroniser bit positions and reset values
    localparam int SI_EOP = 4;
    localparam int SI_IOR = 5;
    localparam int SI_IOW = 6;
    localparam int SI_CS = 7;
    localparam int SI_HOLD = 8;
    localparam int SI_READY = 9;
    localparam logic [9:0] SYNC_RST = 10'h2F0;
    localparam logic [7:0] CMD_RST = 8'h00;
    localparam logic [3:0] MASK_RST = 4'hF;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HOLD_WAIT,
        ST_W1,
        ST_W2,
        ST_W3,
        ST_WAIT,
        ST_W4
    } fcdma_state_t;

endpackage

// ==== verilog/fcdma_sync.sv ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module fcdma_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Pin levels in, filtered levels out
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] out;
    } fcdma_sync_t;

    fcdma_sync_t r;
    fcdma_sync_t n;

    if (WIDTH < 1) begin : g_chk
        $error("fcdma_sync: WIDTH must be at least 1");
    end

    always_comb begin
        n = r;
        n.s1 = async_i;
        n.s2 = r.s1;
        n.s3 = r.s2;
        // A change is taken once the last two stages agree
        for (int i = 0; i < WIDTH; i++) begin
            if (r.s2[i] == r.s3[i]) begin
                n.out[i] = r.s3[i];
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            r <= n;
        end
    end

    assign sync_o = r.out;

endmodule

// ==== verilog/fcdma_top.sv ====
// Four-channel DMA controller with pin-level CPU programming and transfer sequencing
`timescale 1ns/1ps

// How it works
// - Everything runs and is paced from the single clock input.
// - Chip select low enables CPU register access; strobes toggle per access.
// - Reset clears command, status, request, temporary, byte pointer; sets masks; idle.
// - Ready low inserts wait states before the final working state.
// - No transfer starts until the CPU grants the hold.
// - Four asynchronous requests; channel 0 highest, channel 3 lowest priority.
// - Request active level programmable; active high after reset.
// - CPU reads get registers on data lines; CPU writes load control registers.
// - Upper address byte goes on data lines with an address strobe pulse.
// - Memory-to-memory keeps the source byte in the temporary register.
// - I/O read is a CPU input when idle, a driven strobe in transfers other than memory copy.
// - I/O write is a CPU input when idle, a driven strobe in transfers other than memory copy.
// - Count reaching zero pulses end-of-process low; peripherals may pull it.
// - End-of-process stops the channel, sets its count flag, clears its request.
// - Autoinit reloads current from base; otherwise the mask bit is set.
// - Memory copy ends on channel 1 count; external end only with active channel.
// - Low address lines select registers when idle, carry address bits when active.
// - Middle address lines drive bits 7..4 only during service.
// - Hold request rises for software or unmasked hardware requests.
// - At most one acknowledge, only while owning the bus; polarity programmable.
// - Address enable drives during transfers; chip select ignored then.
// - Memory read strobe for read and copy; memory write for write and copy.
// - One clock per state: idle, hold wait, four working states.
// - Idle samples requests each clock; programming needs chip select and no grant.
// - Byte pointer selects low or high byte; cleared by reset, clear, command.
// - A memory copy takes a read half and a write half of four states each.
module fcdma_top #(
    parameter int NCH = fcdma_pkg::NCH
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // CPU bus handshake
    input wire logic cs_n_i,
    input wire logic ready_i,
    input wire logic hold_grant_i,
    output logic hold_request_o,
    output logic address_enable_o,
    output logic upper_address_strobe_o,
    // Peripheral handshake
    input wire logic [3:0] channel_request_i,
    output logic [3:0] channel_ack_o,
    input wire logic end_of_process_n_i,
    output logic end_of_process_n_o,
    output logic end_of_process_n_oe_o,
    // Strobes
    input wire logic io_read_n_i,
    output logic io_read_n_o,
    output logic io_read_n_oe_o,
    input wire logic io_write_n_i,
    output logic io_write_n_o,
    output logic io_write_n_oe_o,
    output logic mem_read_n_o,
    output logic mem_write_n_o,
    output logic mem_strobe_oe_o,
    // Address and data
    input wire logic [3:0] low_address_lines_i,
    output logic [3:0] low_address_lines_o,
    output logic low_address_lines_oe_o,
    output logic [3:0] middle_address_lines_o,
    output logic middle_address_lines_oe_o,
    input wire logic [7:0] data_lines_i,
    output logic [7:0] data_lines_o,
    output logic data_lines_oe_o
);

    typedef struct packed {
        fcdma_pkg::fcdma_state_t state;
        logic [1:0] ch;
        logic mm_half;
        logic eop_seen;
        logic ptr;
        logic rd_q;
        logic wr_q;
        logic [7:0] cmd;
        logic [7:0] status;
        logic [3:0] req;
        logic [3:0] mask;
        logic [7:0] temp;
        logic [3:0][5:0] mode;
        logic [3:0][15:0] base_addr;
        logic [3:0][15:0] base_cnt;
        logic [3:0][15:0] cur_addr;
        logic [3:0][15:0] cur_cnt;
        logic hold_request;
        logic [3:0] ack;
        logic address_enable;
        logic upper_address_strobe;
        logic eop_oe;
        logic io_read_n;
        logic io_write_n;
        logic io_oe;
        logic mem_read_n;
        logic mem_write_n;
        logic mem_oe;
        logic [3:0] lo_addr;
        logic [3:0] mid_addr;
        logic addr_oe;
        logic [7:0] db;
        logic db_oe;
    } fcdma_regs_t;

    fcdma_regs_t r;
    fcdma_regs_t n;
    logic [9:0] sync_q;
    logic [3:0] req_hw;
    logic [3:0] pend;
    logic ext_eop;
    logic prog;
    logic wr_rise;
    logic rd_rise;

    if (NCH != 4) begin : g_chk
        $error("fcdma_top: NCH must be 4");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Lowest numbered pending channel wins
    function automatic logic [1:0] pick(input logic [3:0] p);
        logic [1:0] c;
        c = 2'h3;
        for (int i = 3; i >= 0; i--) begin
            if (p[i]) begin
                c = 2'(i);
            end
        end
        return c;
    endfunction

    function automatic logic [15:0] step(input logic [15:0] a, input logic down);
        return down ? a - 16'h0001 : a + 16'h0001;
    endfunction

    function automatic logic [3:0] onehot(input logic [1:0] c);
        return 4'h1 << c;
    endfunction

    // Cleared control state, channel address and count registers kept
    function automatic fcdma_regs_t cleared(input fcdma_regs_t keep);
        fcdma_regs_t c;
        c = '0;
        c.state = fcdma_pkg::ST_IDLE;
        c.cmd = fcdma_pkg::CMD_RST;
        c.mask = fcdma_pkg::MASK_RST;
        c.ack = 4'hF;
        c.rd_q = 1'b1;
        c.wr_q = 1'b1;
        c.io_read_n = 1'b1;
        c.io_write_n = 1'b1;
        c.mem_read_n = 1'b1;
        c.mem_write_n = 1'b1;
        c.mode = keep.mode;
        c.base_addr = keep.base_addr;
        c.base_cnt = keep.base_cnt;
        c.cur_addr = keep.cur_addr;
        c.cur_cnt = keep.cur_cnt;
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    fcdma_sync #(
        .WIDTH(10),
        .RST_VAL(fcdma_pkg::SYNC_RST)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .async_i({ready_i, hold_grant_i, cs_n_i, io_write_n_i, io_read_n_i,
                  end_of_process_n_i, channel_request_i}),
        .sync_o(sync_q)
    );

    assign req_hw = sync_q[3:0] ^ {4{r.cmd[fcdma_pkg::CMD_REQ_LOW]}};
    // Our own end pulse is not taken back as an external one
    assign ext_eop = ~sync_q[fcdma_pkg::SI_EOP] & ~r.eop_oe;
    assign pend = (r.req | (req_hw & ~r.mask)) & {4{~r.cmd[fcdma_pkg::CMD_DISABLE]}};
    assign prog = ~sync_q[fcdma_pkg::SI_CS] & ~sync_q[fcdma_pkg::SI_HOLD];
    assign wr_rise = sync_q[fcdma_pkg::SI_IOW] & ~r.wr_q;
    assign rd_rise = sync_q[fcdma_pkg::SI_IOR] & ~r.rd_q;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [3:0] ra;
        logic [7:0] d;
        logic [1:0] cw;
        logic [1:0] sel;
        logic [5:0] md;
        logic mm;
        logic tc;
        logic [15:0] cnt;
        logic [3:0] hit;
        ra = low_address_lines_i;
        d = data_lines_i;
        cw = ra[2:1];
        mm = r.cmd[fcdma_pkg::CMD_MEM2MEM] && (r.ch == 2'h0);
        sel = r.mm_half ? 2'h1 : r.ch;
        md = r.mode[r.ch];
        tc = 1'b0;
        cnt = r.cur_cnt[sel] - 16'h0001;
        hit = 4'h0;
        n = r;
        n.rd_q = sync_q[fcdma_pkg::SI_IOR];
        n.wr_q = sync_q[fcdma_pkg::SI_IOW];
        n.upper_address_strobe = 1'b0;
        n.eop_oe = 1'b0;
        n.status[7:4] = req_hw;
        if (ext_eop && r.state >= fcdma_pkg::ST_W1) begin
            n.eop_seen = 1'b1;
        end
        // Default: released bus, inactive acknowledge
        n.hold_request = 1'b0;
        n.ack = {4{~r.cmd[fcdma_pkg::CMD_ACK_HIGH]}};
        n.address_enable = 1'b0;
        n.addr_oe = 1'b0;
        n.io_oe = 1'b0;
        n.mem_oe = 1'b0;
        n.db_oe = 1'b0;
        n.io_read_n = 1'b1;
        n.io_write_n = 1'b1;
        n.mem_read_n = 1'b1;
        n.mem_write_n = 1'b1;
        n.state = fcdma_pkg::ST_IDLE;
        case (r.state)
            fcdma_pkg::ST_IDLE: begin
                if (prog) begin
                    if (wr_rise) begin
                        if (!ra[3]) begin
                            if (ra[0]) begin
                                n.base_cnt[cw][{r.ptr, 3'b000} +: 8] = d;
                                n.cur_cnt[cw][{r.ptr, 3'b000} +: 8] = d;
                            end else begin
                                n.base_addr[cw][{r.ptr, 3'b000} +: 8] = d;
                                n.cur_addr[cw][{r.ptr, 3'b000} +: 8] = d;
                            end
                            n.ptr = ~r.ptr;
                        end else begin
                            case (ra)
                                fcdma_pkg::RS_CMD_STAT: n.cmd = d;
                                fcdma_pkg::RS_REQUEST: n.req[d[1:0]] = d[2];
                                fcdma_pkg::RS_MASK_ONE: n.mask[d[1:0]] = d[2];
                                fcdma_pkg::RS_MODE: n.mode[d[1:0]] = d[7:2];
                                fcdma_pkg::RS_CLR_PTR: n.ptr = 1'b0;
                                fcdma_pkg::RS_MCLR_TEMP: n = cleared(r);
                                fcdma_pkg::RS_CLR_MASK: n.mask = 4'h0;
                                fcdma_pkg::RS_ALL_MASK: n.mask = d[3:0];
                                default: n.ptr = r.ptr;
                            endcase
                        end
                    end
                    if (rd_rise) begin
                        if (!ra[3]) begin
                            n.ptr = ~r.ptr;
                        end else if (ra == fcdma_pkg::RS_CMD_STAT) begin
                            n.status[3:0] = 4'h0;
                        end
                    end
                    if (!sync_q[fcdma_pkg::SI_IOR]) begin
                        n.db_oe = 1'b1;
                        if (!ra[3]) begin
                            n.db = ra[0] ? r.cur_cnt[cw][{r.ptr, 3'b000} +: 8]
                                         : r.cur_addr[cw][{r.ptr, 3'b000} +: 8];
                        end else if (ra == fcdma_pkg::RS_CMD_STAT) begin
                            n.db = r.status;
                        end else if (ra == fcdma_pkg::RS_MCLR_TEMP) begin
                            n.db = r.temp;
                        end else begin
                            n.db = 8'h00;
                        end
                    end
                end else if (|pend && !sync_q[fcdma_pkg::SI_HOLD]) begin
                    n.hold_request = 1'b1;
                    n.ch = pick(pend);
                    n.mm_half = 1'b0;
                    n.state = fcdma_pkg::ST_HOLD_WAIT;
                end
            end
            fcdma_pkg::ST_HOLD_WAIT: begin
                if (|pend) begin
                    n.hold_request = 1'b1;
                    n.ch = pick(pend);
                    n.state = sync_q[fcdma_pkg::SI_HOLD] ? fcdma_pkg::ST_W1 : fcdma_pkg::ST_HOLD_WAIT;
                end
            end
            default: begin
                if (sync_q[fcdma_pkg::SI_HOLD]) begin
                    n.hold_request = 1'b1;
                    if (md[fcdma_pkg::MODE_SVC +: 2] == fcdma_pkg::SVC_CASCADE && !mm) begin
                        n.ack = onehot(r.ch) ^ {4{~r.cmd[fcdma_pkg::CMD_ACK_HIGH]}};
                        n.state = req_hw[r.ch] ? fcdma_pkg::ST_W1 : fcdma_pkg::ST_IDLE;
                        n.hold_request = req_hw[r.ch];
                    end else begin
                        n.address_enable = 1'b1;
                        n.addr_oe = 1'b1;
                        n.lo_addr = r.cur_addr[sel][3:0];
                        n.mid_addr = r.cur_addr[sel][7:4];
                        n.mem_oe = 1'b1;
                        n.io_oe = ~mm;
                        if (!mm) begin
                            n.ack = onehot(r.ch) ^ {4{~r.cmd[fcdma_pkg::CMD_ACK_HIGH]}};
                        end
                        case (r.state)
                            fcdma_pkg::ST_W1: begin
                                n.eop_seen = ext_eop;
                                n.db = r.cur_addr[sel][15:8];
                                n.db_oe = 1'b1;
                                n.upper_address_strobe = 1'b1;
                                n.state = fcdma_pkg::ST_W2;
                            end
                            fcdma_pkg::ST_W2, fcdma_pkg::ST_W3, fcdma_pkg::ST_WAIT: begin
                                n.db = r.temp;
                                n.db_oe = mm && r.mm_half;
                                if (mm) begin
                                    n.mem_read_n = r.mm_half;
                                    n.mem_write_n = ~(r.mm_half && r.state != fcdma_pkg::ST_W2);
                                end else begin
                                    n.io_read_n = md[1:0] != fcdma_pkg::XFER_WRITE;
                                    n.mem_read_n = md[1:0] != fcdma_pkg::XFER_READ;
                                    if (r.state != fcdma_pkg::ST_W2) begin
                                        n.mem_write_n = md[1:0] != fcdma_pkg::XFER_WRITE;
                                        n.io_write_n = md[1:0] != fcdma_pkg::XFER_READ;
                                    end
                                end
                                if (r.state == fcdma_pkg::ST_W2) begin
                                    n.state = fcdma_pkg::ST_W3;
                                end else begin
                                    n.state = sync_q[fcdma_pkg::SI_READY] ? fcdma_pkg::ST_W4 : fcdma_pkg::ST_WAIT;
                                end
                            end
                            fcdma_pkg::ST_W4: begin
                                n.cur_addr[sel] = step(r.cur_addr[sel], r.mode[sel][fcdma_pkg::MODE_DEC]);
                                if (mm && !r.mm_half) begin
                                    n.temp = d;
                                    n.mm_half = 1'b1;
                                end else begin
                                    n.cur_cnt[sel] = cnt;
                                    tc = cnt == 16'h0000;
                                    n.mm_half = 1'b0;
                                end
                                n.eop_oe = tc;
                                n.state = fcdma_pkg::ST_W1;
                                if (tc || n.eop_seen) begin
                                    hit = mm ? 4'h3 : onehot(r.ch);
                                    for (int i = 0; i < 4; i++) begin
                                        if (hit[i]) begin
                                            n.status[i] = 1'b1;
                                            n.req[i] = 1'b0;
                                            if (r.mode[i][fcdma_pkg::MODE_AUTO]) begin
                                                n.cur_addr[i] = r.base_addr[i];
                                                n.cur_cnt[i] = r.base_cnt[i];
                                            end else begin
                                                n.mask[i] = 1'b1;
                                            end
                                        end
                                    end
                                    n.state = fcdma_pkg::ST_IDLE;
                                end else if (!mm && (md[fcdma_pkg::MODE_SVC +: 2] == fcdma_pkg::SVC_SINGLE ||
                                             (md[fcdma_pkg::MODE_SVC +: 2] == fcdma_pkg::SVC_DEMAND &&
                                              !req_hw[r.ch]))) begin
                                    n.state = fcdma_pkg::ST_IDLE;
                                end
                                if (n.state == fcdma_pkg::ST_IDLE) begin
                                    n.hold_request = 1'b0;
                                end
                            end
                            default: n.state = fcdma_pkg::ST_IDLE;
                        endcase
                    end
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= cleared('0);
        end else begin
            r <= n;
        end
    end

    assign hold_request_o = r.hold_request;
    assign address_enable_o = r.address_enable;
    assign upper_address_strobe_o = r.upper_address_strobe;
    assign channel_ack_o = r.ack;
    assign end_of_process_n_o = 1'b0;
    assign end_of_process_n_oe_o = r.eop_oe;
    assign io_read_n_o = r.io_read_n;
    assign io_read_n_oe_o = r.io_oe;
    assign io_write_n_o = r.io_write_n;
    assign io_write_n_oe_o = r.io_oe;
    assign mem_read_n_o = r.mem_read_n;
    assign mem_write_n_o = r.mem_write_n;
    assign mem_strobe_oe_o = r.mem_oe;
    assign low_address_lines_o = r.lo_addr;
    assign low_address_lines_oe_o = r.addr_oe;
    assign middle_address_lines_o = r.mid_addr;
    assign middle_address_lines_oe_o = r.addr_oe;
    assign data_lines_o = r.db;
    assign data_lines_oe_o = r.db_oe;

endmodule

// ==== verif/fcdma_properties.sv ====
// Pin-level temporal checks for the DMA controller
`timescale 1ns/1ps
module fcdma_properties (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic hold_grant_i,
    input wire logic hold_request_o,
    input wire logic address_enable_o,
    input wire logic upper_address_strobe_o,
    input wire logic [3:0] channel_ack_o,
    input wire logic end_of_process_n_oe_o,
    input wire logic io_write_n_o,
    input wire logic io_write_n_oe_o,
    input wire logic mem_write_n_o,
    input wire logic middle_address_lines_oe_o,
    input wire logic data_lines_oe_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    ack_onehot_a: assert property ($onehot0(~channel_ack_o) || $onehot0(channel_ack_o)) else $error("two acks");
    ack_owner_a: assert property (!(channel_ack_o inside {4'h0, 4'hF}) |-> hold_grant_i) else $error("ack");
    grant_first_a: assert property ($rose(address_enable_o) |-> $past(hold_grant_i, 2)) else $error("no grant");
    hold_wait_a: assert property ($rose(hold_request_o) |-> !address_enable_o [*3]) else $error("early");
    strobe_pulse_a: assert property (upper_address_strobe_o |-> data_lines_oe_o ##1 !upper_address_strobe_o)
        else $error("strobe");
    mid_addr_a: assert property (middle_address_lines_oe_o |-> address_enable_o) else $error("address");
    eop_pulse_a: assert property (end_of_process_n_oe_o |=> !end_of_process_n_oe_o) else $error("end pulse");
    read_type_a: assert property (io_write_n_oe_o && !io_write_n_o |-> mem_write_n_o) else $error("strobes");
    cover property ($rose(address_enable_o));
    cover property (end_of_process_n_oe_o);
    cover property (io_write_n_oe_o && !io_write_n_o);
endmodule
bind fcdma_top fcdma_properties u_props (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .hold_grant_i(hold_grant_i),
    .hold_request_o(hold_request_o), .address_enable_o(address_enable_o), .channel_ack_o(channel_ack_o),
    .upper_address_strobe_o(upper_address_strobe_o), .end_of_process_n_oe_o(end_of_process_n_oe_o),
    .io_write_n_o(io_write_n_o), .io_write_n_oe_o(io_write_n_oe_o), .mem_write_n_o(mem_write_n_o),
    .middle_address_lines_oe_o(middle_address_lines_oe_o), .data_lines_oe_o(data_lines_oe_o));

// ==== verif/fcdma_cpu_model.sv ====
// Host CPU stand-in granting the bus after a short or long delay
`timescale 1ns/1ps
module fcdma_cpu_model (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    input wire logic hold_request_i,
    output logic hold_grant_o
);
    logic [3:0] dly_r;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dly_r <= 4'h0;
            hold_grant_o <= 1'b0;
        end else begin
            dly_r <= !hold_request_i ? 4'h0 : (dly_r == 4'hF ? dly_r : dly_r + 4'h1);
            hold_grant_o <= hold_request_i && dly_r >= (slow_i ? 4'h8 : 4'h1);
        end
    end
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the DMA controller with a host stand-in
`timescale 1ns/1ps
module testbench;
    logic ref_clk_i = 1'b0, rst_n_i = 1'b0, cs_n = 1'b1, ior_n = 1'b1, iow_n = 1'b1, rdy = 1'b1;
    logic grant, hold_request, address_enable, upper_address_strobe, eop_oe, ior_o, ior_oe, iow_o, iow_oe, mem_read_n, mem_write_n, la_oe, ma_oe, db_oe, moe, eop_o;
    logic [3:0] req = 4'h0, sel = 4'h0, ack, la_o, ma_o;
    logic [7:0] din = 8'hA5, db_o, rdv;
    int fails = 0, n_checks = 0, cyc = 0;
    always #2 ref_clk_i = ~ref_clk_i;
    fcdma_cpu_model u_cpu (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .slow_i(1'b1), .hold_request_i(hold_request),
        .hold_grant_o(grant));
    fcdma_top DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .ready_i(rdy), .hold_grant_i(grant),
        .hold_request_o(hold_request), .address_enable_o(address_enable), .upper_address_strobe_o(upper_address_strobe), .channel_request_i(req),
        .channel_ack_o(ack), .end_of_process_n_i(eop_oe ? eop_o : 1'b1), .end_of_process_n_o(eop_o),
        .end_of_process_n_oe_o(eop_oe),
        .io_read_n_i(ior_oe ? ior_o : ior_n), .io_read_n_o(ior_o), .io_read_n_oe_o(ior_oe),
        .io_write_n_i(iow_oe ? iow_o : iow_n), .io_write_n_o(iow_o), .io_write_n_oe_o(iow_oe),
        .mem_read_n_o(mem_read_n), .mem_write_n_o(mem_write_n), .mem_strobe_oe_o(moe), .low_address_lines_i(la_oe ? la_o : sel),
        .low_address_lines_o(la_o), .low_address_lines_oe_o(la_oe), .middle_address_lines_o(ma_o),
        .middle_address_lines_oe_o(ma_oe), .data_lines_i(db_oe ? db_o : din), .data_lines_o(db_o),
        .data_lines_oe_o(db_oe));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        if (fails == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Chip select stays low across writes; each byte ends with a strobe rise
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        cs_n <= 1'b0;
        sel <= a;
        din <= d;
        iow_n <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        iow_n <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk_i);
        cs_n <= 1'b0;
        sel <= a;
        ior_n <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        #1 rdv = db_o;
        @(posedge ref_clk_i);
        ior_n <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
    endtask
    task automatic t_masked();
        wr(4'hB, 8'h8A);
        wr(4'hC, 8'h00);
        wr(4'h4, 8'h34);
        wr(4'h4, 8'h12);
        wr(4'h5, 8'h01);
        wr(4'h5, 8'h00);
        cs_n <= 1'b1;
        req <= 4'hF;
        repeat (12) @(posedge ref_clk_i);
        chk(hold_request, 1'b0);
    endtask
    task automatic t_transfer();
        wr(4'hA, 8'h02);
        cs_n <= 1'b1;
        wait (upper_address_strobe === 1'b1);
        #1;
        chk(db_o, 8'h12);
        chk({ma_o, la_o}, 8'h34);
        chk(ack, 4'hB);
        wait (mem_read_n === 1'b0);
        @(posedge ref_clk_i);
        #1;
        chk({iow_o, iow_oe, mem_write_n, moe}, 4'h7);
        wait (eop_oe === 1'b1);
        repeat (16) @(posedge ref_clk_i);
        chk({hold_request, address_enable}, 2'h0);
    endtask
    // Channels 2 and 3 both pending; ready held low stretches the strobes
    task automatic t_wait();
        wr(4'h5, 8'h01);
        wr(4'h5, 8'h00);
        wr(4'hF, 8'h03);
        cs_n <= 1'b1;
        rdy <= 1'b0;
        wait (upper_address_strobe === 1'b1);
        req <= 4'h4;
        #1;
        chk(ack, 4'hB);
        chk(la_o, 4'h5);
        wait (mem_read_n === 1'b0);
        repeat (10) @(posedge ref_clk_i);
        #1;
        chk(mem_read_n, 1'b0);
        @(posedge ref_clk_i);
        rdy <= 1'b1;
        wait (eop_oe === 1'b1);
        repeat (16) @(posedge ref_clk_i);
        chk(hold_request, 1'b0);
    endtask
    task automatic t_status();
        rd(4'h8);
        chk(rdv & 8'h0F, 8'h04);
        rd(4'h8);
        chk(rdv & 8'h0F, 8'h00);
    endtask
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk_i);
        chk({hold_request, address_enable, 2'h0, ack}, 8'h0F);
        rst_n_i <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        t_masked();
        t_transfer();
        t_wait();
        t_status();
        conclude();
    end
endmodule
